/* File: verilog/ctm_timer.sv */
// compact 10-bit timer: counter, comparators A and P, output pin logic
// assumes a plain register port on mclk; read data follow a read by one cycle
`timescale 1ns/10ps
module ctm_timer
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // counter clock sources
  input  wire logic       sub_clk,
  input  wire logic       ext_clk,
  // output pin
  output logic            timer_output_pin,
  output logic            timer_output_pin_oe_n,
  // match flags
  output logic            match_a_flag,
  output logic            match_p_flag
);
  import ctm_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]            ctrl0;
  logic [7:0]            ctrl1;
  logic [CTM_CNT_W-1:0]  compare_a_value;
  logic [CTM_CNT_W-1:0]  cnt;
  logic                  pin;
  logic                  en_d;
  logic                  flag_a;
  logic                  flag_p;
  logic [7:0]            rdata;

  logic [7:0]            next_ctrl0;
  logic [7:0]            next_ctrl1;
  logic [CTM_CNT_W-1:0]  next_compare_a_value;
  logic [CTM_CNT_W-1:0]  next_cnt;
  logic                  next_pin;
  logic                  next_en_d;
  logic                  next_flag_a;
  logic                  next_flag_p;
  logic [7:0]            next_rdata;

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  logic                  counter_enable;
  logic [CTM_CODE_W-1:0] period_code;
  ctm_mode_t             mode;
  logic [1:0]            pin_action;
  logic                  output_control;
  logic                  output_polarity;
  logic                  duty_period_select;
  logic                  clear_select;
  logic                  en_rise;
  logic                  tick;
  logic                  hit_a;
  logic                  hit_p;
  logic                  wrap;
  logic                  set_a;
  logic                  set_p;
  logic                  clr_cnt;
  logic [CTM_CNT_W:0]    period_len;
  logic [CTM_CNT_W:0]    duty_len;
  logic [CTM_CNT_W:0]    pos;
  logic                  pwm_active;
  logic                  pwm_level;

  ctm_tick_if tk ();

  assign counter_enable     = ctrl0[CTM_C0_ENABLE];
  assign period_code        = ctrl0[CTM_C0_CODE_LSB +: CTM_CODE_W];
  assign tk.sel             = ctrl0[CTM_C0_CLK_LSB +: 3];
  assign mode               = ctm_mode_t'(ctrl1[CTM_C1_MODE_LSB +: 2]);
  assign pin_action         = ctrl1[CTM_C1_ACT_LSB +: 2];
  assign output_control     = ctrl1[CTM_C1_OC];
  assign output_polarity    = ctrl1[CTM_C1_POL];
  assign duty_period_select = ctrl1[CTM_C1_DPX];
  assign clear_select       = ctrl1[CTM_C1_CCLR];
  assign en_rise            = counter_enable & ~en_d;
  assign tick               = tk.tick;

  ctm_prescale u_pre (
    .mclk    (mclk),
    .rst     (rst),
    .sub_clk (sub_clk),
    .ext_clk (ext_clk),
    .tk      (tk.pre)
  );

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  always_comb
  begin
    // matches are checked on the count just reached
    hit_a = tick && counter_enable && !en_rise && (compare_a_value != 10'h000)
            && (cnt == compare_a_value);
    // period code matches the top three counter bits while the low seven are zero
    hit_p = tick && counter_enable && !en_rise && (period_code != 3'h0)
            && (cnt[CTM_CNT_W-1 -: CTM_CODE_W] == period_code)
            && (cnt[CTM_CNT_W-4:0] == 7'h00);
    wrap  = tick && counter_enable && !en_rise && (cnt == CTM_CNT_MAX);
    // period in counter clocks; code zero spans the whole counter
    period_len = (period_code == 3'h0) ? {1'b1, 10'h000}
                                       : {1'b0, period_code, 7'h00};
    duty_len   = {1'b0, compare_a_value};
    if (duty_period_select)
    begin
      period_len = {1'b0, compare_a_value};
      duty_len   = (period_code == 3'h0) ? {1'b1, 10'h000}
                                         : {1'b0, period_code, 7'h00};
    end
    pos        = {1'b0, cnt};
    pwm_active = (duty_len >= period_len) || (pos < duty_len);
  end

  // ---------------------------------------------------------------
  // clear and flag selection
  // ---------------------------------------------------------------
  always_comb
  begin
    set_a   = 1'b0;
    set_p   = 1'b0;
    clr_cnt = 1'b0;
    case (mode)
      CTM_MODE_PWM:
      begin
        // clear-select plays no part here
        set_a   = hit_a;
        set_p   = hit_p;
        clr_cnt = duty_period_select ? hit_a : (hit_p | wrap);
      end
      CTM_MODE_CMP,
      CTM_MODE_TMR:
      begin
        if (clear_select)
        begin
          set_a   = hit_a;
          clr_cnt = hit_a | wrap;
        end
        else
        begin
          set_a   = hit_a;
          set_p   = hit_p;
          clr_cnt = hit_p | wrap;
        end
      end
      default:
      begin
        set_a   = 1'b0;
        set_p   = 1'b0;
        clr_cnt = wrap;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // counter, pin and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    next_en_d = counter_enable;
    next_cnt  = cnt;
    if (en_rise)
      next_cnt = 10'h000;
    else if (counter_enable && tick)
      next_cnt = clr_cnt ? 10'h000 : cnt + 10'h001;

    next_pin = pin;
    if (en_rise)
      next_pin = output_control;
    else if (mode == CTM_MODE_CMP && set_a)
    begin
      // only the A match moves the pin
      case (pin_action)
        CTM_ACT_LOW:    next_pin = 1'b0;
        CTM_ACT_HIGH:   next_pin = 1'b1;
        CTM_ACT_TOGGLE: next_pin = ~pin;
        default:        next_pin = pin;
      endcase
    end

    // set wins over a write-one clear in the same cycle
    next_flag_a = flag_a;
    next_flag_p = flag_p;
    if (reg_wr && reg_addr == CTM_ADDR_FLAGS)
    begin
      if (reg_wdata[CTM_FL_A])
        next_flag_a = 1'b0;
      if (reg_wdata[CTM_FL_P])
        next_flag_p = 1'b0;
    end
    if (set_a)
      next_flag_a = 1'b1;
    if (set_p)
      next_flag_p = 1'b1;
  end

  // pwm level: forced or running waveform; counting goes on regardless
  always_comb
  begin
    case (pin_action)
      CTM_ACT_KEEP: pwm_level = ~output_control;
      CTM_ACT_LOW:  pwm_level = output_control;
      CTM_ACT_HIGH: pwm_level = pwm_active ? output_control : ~output_control;
      default:      pwm_level = ~output_control;
    endcase
  end

  always_comb
  begin
    // timer/counter mode leaves the pin to other functions
    timer_output_pin_oe_n = (mode == CTM_MODE_TMR);
    case (mode)
      CTM_MODE_PWM: timer_output_pin = pwm_level ^ output_polarity;
      CTM_MODE_CMP: timer_output_pin = pin ^ output_polarity;
      default:      timer_output_pin = 1'b0;
    endcase
  end

  assign match_a_flag = flag_a;
  assign match_p_flag = flag_p;

  // ---------------------------------------------------------------
  // register writes and reads
  // ---------------------------------------------------------------
  always_comb
  begin
    next_ctrl0           = ctrl0;
    next_ctrl1           = ctrl1;
    next_compare_a_value = compare_a_value;
    if (reg_wr)
    begin
      case (reg_addr)
        CTM_ADDR_CTRL0:   next_ctrl0 = {1'b0, reg_wdata[6:0]};
        CTM_ADDR_CTRL1:   next_ctrl1 = reg_wdata;
        CTM_ADDR_CMPA_LO: next_compare_a_value[7:0] = reg_wdata;
        CTM_ADDR_CMPA_HI: next_compare_a_value[9:8] = reg_wdata[1:0];
        default:          next_ctrl0 = ctrl0;
      endcase
    end
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        CTM_ADDR_CTRL0:   next_rdata = ctrl0;
        CTM_ADDR_CTRL1:   next_rdata = ctrl1;
        CTM_ADDR_CNT_LO:  next_rdata = cnt[7:0];
        CTM_ADDR_CNT_HI:  next_rdata = {6'h00, cnt[9:8]};
        CTM_ADDR_CMPA_LO: next_rdata = compare_a_value[7:0];
        CTM_ADDR_CMPA_HI: next_rdata = {6'h00, compare_a_value[9:8]};
        CTM_ADDR_FLAGS:   next_rdata = {6'h00, flag_p, flag_a};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl0           <= CTM_RESET_BYTE;
      ctrl1           <= CTM_RESET_BYTE;
      compare_a_value <= 10'h000;
      cnt             <= 10'h000;
      pin             <= 1'b0;
      en_d            <= 1'b0;
      flag_a          <= 1'b0;
      flag_p          <= 1'b0;
      rdata           <= 8'h00;
    end
    else
    begin
      ctrl0           <= next_ctrl0;
      ctrl1           <= next_ctrl1;
      compare_a_value <= next_compare_a_value;
      cnt             <= next_cnt;
      pin             <= next_pin;
      en_d            <= next_en_d;
      flag_a          <= next_flag_a;
      flag_p          <= next_flag_p;
      rdata           <= next_rdata;
    end
  end

endmodule // ctm_timer

/* File: common/ctm_pkg.sv */
// constants, register map and types of the compact timer
// assumes a single clock mclk at 20 MHz and a plain register port
//
// Behaviour
// - compare-A high byte holds bits 9..8 in bits 1..0, others read zero
// - mode field: 00 compare output, 11 timer/counter, 10 PWM
// - clear-select low: clear on P match or overflow at code zero; both flags
// - clear-select high: clear on A match; only A flag raised
// - clear-select high, compare-A zero: wrap at 3FF without A flag
// - compare mode: pin changes only on A match, never on P match
// - A match drives pin high, low or toggles; code zero leaves it
// - enable rising edge sets pin to output-control initial level
// - timer/counter mode counts and flags like compare mode; pin not driven
// - PWM ignores clear-select; period source clears counter, other sets duty
// - duty/period select zero: period code times 128, 000 means 1024
// - duty/period select one: compare-A is period, period code is duty
// - duty at or above period gives 100 percent active output
// - PWM raises A flag on A match and P flag on P match
// - PWM: output-control picks active level, pin-action forces, polarity inverts
// - forced PWM levels keep counting and matching running
// - period code compares with counter bits 9..7; bits 6..0 must be zero
// - enable rise zeroes counter; enable low holds counter value
// - compare: 01 low, 10 high, 11 toggle; PWM 00 inactive, 01 active

package ctm_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [2:0] CTM_ADDR_CTRL0   = 3'h0;
  localparam logic [2:0] CTM_ADDR_CTRL1   = 3'h1;
  localparam logic [2:0] CTM_ADDR_CNT_LO  = 3'h2;
  localparam logic [2:0] CTM_ADDR_CNT_HI  = 3'h3;
  localparam logic [2:0] CTM_ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] CTM_ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] CTM_ADDR_FLAGS   = 3'h6;

  // ctrl0 fields
  localparam int CTM_C0_ENABLE   = 3;
  localparam int CTM_C0_CLK_LSB  = 4;
  localparam int CTM_C0_CODE_LSB = 0;
  // ctrl1 fields
  localparam int CTM_C1_MODE_LSB = 6;
  localparam int CTM_C1_ACT_LSB  = 4;
  localparam int CTM_C1_OC       = 3;
  localparam int CTM_C1_POL      = 2;
  localparam int CTM_C1_DPX      = 1;
  localparam int CTM_C1_CCLR     = 0;
  // flag register fields, write one to clear
  localparam int CTM_FL_A        = 0;
  localparam int CTM_FL_P        = 1;

  localparam logic [7:0] CTM_RESET_BYTE = 8'h00;
  localparam logic [9:0] CTM_CNT_MAX    = 10'h3ff;
  localparam int         CTM_CNT_W      = 10;
  localparam int         CTM_CODE_W     = 3;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UND = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_t;

  localparam logic [1:0] CTM_ACT_KEEP   = 2'h0;
  localparam logic [1:0] CTM_ACT_LOW    = 2'h1;
  localparam logic [1:0] CTM_ACT_HIGH   = 2'h2;
  localparam logic [1:0] CTM_ACT_TOGGLE = 2'h3;

  // counter clock selects; the fast internal taps are divisions of mclk
  localparam logic [2:0] CTM_CK_DIV4    = 3'h0;
  localparam logic [2:0] CTM_CK_SYS     = 3'h1;
  localparam logic [2:0] CTM_CK_H16     = 3'h2;
  localparam logic [2:0] CTM_CK_H64     = 3'h3;
  localparam logic [2:0] CTM_CK_SUB0    = 3'h4;
  localparam logic [2:0] CTM_CK_SUB1    = 3'h5;
  localparam logic [2:0] CTM_CK_PIN_R   = 3'h6;
  localparam logic [2:0] CTM_CK_PIN_F   = 3'h7;
  localparam int         CTM_PRE_W      = 6;

endpackage

/* File: common/ctm_tick_if.sv */
// carries the counter-clock tick from the prescaler to the timer core
// assumes both ends run on mclk
`timescale 1ns/10ps
interface ctm_tick_if;
  logic [2:0] sel;
  logic       tick;
  modport core (output sel, input tick);
  modport pre  (input sel, output tick);
endinterface // ctm_tick_if

/* File: verilog/ctm_prescale.sv */
// counter-clock prescaler: turns the clock select into one-cycle ticks
// assumes sub clock and external clock pins are synchronous to mclk
`timescale 1ns/10ps
module ctm_prescale
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // sources
  input  wire logic sub_clk,
  input  wire logic ext_clk,
  // tick to core
  ctm_tick_if.pre   tk
);
  import ctm_pkg::*;

  logic [CTM_PRE_W-1:0] pre_cnt;
  logic [CTM_PRE_W-1:0] next_pre_cnt;
  logic                 sub_d;
  logic                 ext_d;
  logic                 next_sub_d;
  logic                 next_ext_d;
  logic                 tick_c;

  always_comb
  begin
    next_pre_cnt = pre_cnt + 6'h01;
    next_sub_d   = sub_clk;
    next_ext_d   = ext_clk;
    case (tk.sel)
      CTM_CK_DIV4:  tick_c = (pre_cnt[1:0] == 2'h3);
      CTM_CK_SYS:   tick_c = 1'b1;
      CTM_CK_H16:   tick_c = (pre_cnt[3:0] == 4'hf);
      CTM_CK_H64:   tick_c = (pre_cnt == 6'h3f);
      CTM_CK_SUB0,
      CTM_CK_SUB1:  tick_c = sub_clk & ~sub_d;
      CTM_CK_PIN_R: tick_c = ext_clk & ~ext_d;
      CTM_CK_PIN_F: tick_c = ~ext_clk & ext_d;
      default:      tick_c = 1'b0;
    endcase
  end

  assign tk.tick = tick_c;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_cnt <= 6'h00;
      sub_d   <= 1'b0;
      ext_d   <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      sub_d   <= next_sub_d;
      ext_d   <= next_ext_d;
    end
  end

endmodule // ctm_prescale

/* File: verification/ctm_load_model.sv */
// load model on the timer output pin, counting cycles at high level
// assumes a pull-down holds the pin low while it is released
`timescale 1ns/10ps
module ctm_load_model
(
  // clock and control
  input  wire logic        mclk,
  input  wire logic        clr,
  // pin
  input  wire logic        pin,
  input  wire logic        oe_n,
  // counts
  output logic      [15:0] high_cnt
);
  logic level;

  // released pin falls to the pull-down level
  assign level = oe_n ? 1'b0 : pin;

  always_ff @(posedge mclk)
  begin
    if (clr)
      high_cnt <= 16'h0000;
    else
      high_cnt <= high_cnt + {15'h0000, level};
  end
endmodule // ctm_load_model

/* File: verification/ctm_timer_properties.sv */
// port checker for the compact timer
// assumes it is bound to ctm_timer and watches register writes
`timescale 1ns/10ps
module ctm_timer_chk
  import ctm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       timer_output_pin,
  input  wire logic       timer_output_pin_oe_n,
  input  wire logic       match_a_flag,
  input  wire logic       match_p_flag
);
  logic [7:0] c1;
  logic       en;
  logic       clr_a;
  logic       clr_p;

  // shadow of ctrl1 and the enable bit
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      c1 <= 8'h00;
      en <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == CTM_ADDR_CTRL1)
        c1 <= reg_wdata;
      if (reg_addr == CTM_ADDR_CTRL0)
        en <= reg_wdata[CTM_C0_ENABLE];
    end
  end
  assign clr_a = reg_wr && reg_addr == CTM_ADDR_FLAGS && reg_wdata[CTM_FL_A];
  assign clr_p = reg_wr && reg_addr == CTM_ADDR_FLAGS && reg_wdata[CTM_FL_P];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_cmpa_hi;
    $past(reg_rd) && $past(reg_addr) == CTM_ADDR_CMPA_HI |-> reg_rdata[7:2] == 6'h00;
  endproperty
  a_cmpa_hi: assert property (p_cmpa_hi) else $error("unused bits set");
  property p_tmr_oe;
    c1[7:6] == 2'h3 |-> timer_output_pin_oe_n;
  endproperty
  a_tmr_oe: assert property (p_tmr_oe) else $error("pin driven in timer mode");
  property p_cmp_oe;
    c1[7:6] == 2'h0 |-> !timer_output_pin_oe_n;
  endproperty
  a_cmp_oe: assert property (p_cmp_oe) else $error("pin not driven");
  property p_a_hold;
    match_a_flag && !clr_a |=> match_a_flag;
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("a flag lost");
  property p_p_hold;
    match_p_flag && !clr_p |=> match_p_flag;
  endproperty
  a_p_hold: assert property (p_p_hold) else $error("p flag lost");
  property p_no_p;
    $rose(match_p_flag) |-> !($past(c1[7:6]) != 2'h2 && $past(c1[0]));
  endproperty
  a_no_p: assert property (p_no_p) else $error("p flag with a clear");
  property p_en_pin;
    $rose(en) && c1[7:6] == 2'h0 |=> timer_output_pin == (c1[3] ^ c1[2]);
  endproperty
  a_en_pin: assert property (p_en_pin) else $error("pin not at start level");
  property p_force_lo;
    c1[7:4] == 4'h8 |-> timer_output_pin == !(c1[3] ^ c1[2]);
  endproperty
  a_force_lo: assert property (p_force_lo) else $error("not inactive");
  property p_force_hi;
    c1[7:4] == 4'h9 |-> timer_output_pin == (c1[3] ^ c1[2]);
  endproperty
  a_force_hi: assert property (p_force_hi) else $error("not active");
endmodule // ctm_timer_chk

bind ctm_timer ctm_timer_chk u_ctm_timer_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer_output_pin(timer_output_pin), .timer_output_pin_oe_n(timer_output_pin_oe_n),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

/* File: verification/tb_ctm_timer.sv */
// self-checking bench for the compact timer
// assumes the load model and the bound checker are compiled first
`timescale 1ns/10ps
module tb_ctm_timer;
  import ctm_pkg::*;
  logic        mclk, rst, reg_wr, reg_rd, sub_clk, ext_clk, clr;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d1, d2;
  logic        pin, oe_n, fa, fp;
  logic [15:0] high_cnt;
  int          bad_count, checks, n;
  int          cyc = 0;

  ctm_timer u_ctm_timer (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sub_clk(sub_clk),
    .ext_clk(ext_clk), .timer_output_pin(pin), .timer_output_pin_oe_n(oe_n),
    .match_a_flag(fa), .match_p_flag(fp));
  ctm_load_model u_ctm_load_model (.mclk(mclk), .clr(clr), .pin(pin), .oe_n(oe_n),
    .high_cnt(high_cnt));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // cycle ceiling and slow sources
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    sub_clk <= cyc[3];
    ext_clk <= cyc[2];
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  // cycles until the chosen flag is seen
  task automatic wfl(input bit p, input int lim);
    n = 0;
    while ((p ? fp : fa) !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // stop, configure, clear flags, start with every-cycle ticks
  task automatic go(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] code);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CTRL1, c1);
    wr(CTM_ADDR_CMPA_LO, a[7:0]);
    wr(CTM_ADDR_CMPA_HI, {6'h00, a[9:8]});
    wr(CTM_ADDR_FLAGS, 8'h03);
    wr(CTM_ADDR_CTRL0, {4'h1, 1'b1, code});
  endtask

  // restart the running setup with period code 000 on another counter clock
  task automatic gock(input logic [2:0] s);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_FLAGS, 8'h03);
    wr(CTM_ADDR_CTRL0, {1'b0, s, 1'b1, 3'h0});
  endtask

  task automatic load(input int len, input logic [15:0] e);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (len) @(posedge mclk);
    #1;
    chk(high_cnt, e);
  endtask

  initial
  begin
    {rst, reg_wr, reg_rd, clr} = 4'h9;
    {reg_addr, reg_wdata, bad_count, checks} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(i[2:0], 8'h00);
    wr(CTM_ADDR_CMPA_HI, 8'hff);
    wr(3'h7, 8'hff);
    rdc(CTM_ADDR_CMPA_HI, 8'h03);
    rdc(3'h7, 8'h00);
    go(8'h21, 10'h003, 3'h0);
    wfl(0, 20);
    chk(n[15:0], 16'd5);
    chk({15'h0, pin, fp}, 16'h2);
    gock(CTM_CK_DIV4);
    wfl(0, 40);
    chk({15'h0, n >= 14 && n <= 17}, 16'h1);
    gock(CTM_CK_PIN_R);
    wfl(0, 60);
    chk({15'h0, n >= 26 && n <= 33}, 16'h1);
    for (int i = 0; i < 4; i++)
    begin
      go({2'h0, i[1:0], 4'h9}, 10'h003, 3'h0);
      wfl(0, 20);
      chk({15'h0, pin}, (i == 1 || i == 3) ? 16'h0 : 16'h1);
    end
    go(8'h30, 10'h005, 3'h1);
    wfl(1, 200);
    chk({15'h0, n >= 120 && n <= 140}, 16'h1);
    chk({14'h0, fa, pin}, 16'h3);
    go(8'h21, 10'h000, 3'h0);
    wfl(0, 1100);
    chk({15'h0, fa}, 16'h0);
    wr(CTM_ADDR_CTRL0, 8'h00);
    rd(CTM_ADDR_CNT_LO, d1);
    repeat (5) @(posedge mclk);
    rd(CTM_ADDR_CNT_LO, d2);
    chk({8'h00, d2}, {8'h00, d1});
    go(8'hc1, 10'h003, 3'h0);
    wfl(0, 20);
    chk({n[14:0], oe_n}, {15'd5, 1'b1});
    go(8'h40, 10'h003, 3'h0);
    wfl(0, 20);
    chk({14'h0, fa, pin}, 16'h0);
    go(8'ha9, 10'd200, 3'h1);
    wfl(1, 200);
    chk({15'h0, fp}, 16'h1);
    load(300, 16'd300);
    go(8'hac, 10'd200, 3'h1);
    load(300, 16'd0);
    go(8'haa, 10'd100, 3'h1);
    load(300, 16'd300);
    go(8'ha8, 10'd32, 3'h1);
    load(300, 16'd95);
    go(8'h88, 10'd32, 3'h1);
    wfl(1, 200);
    chk({14'h0, fa, pin}, 16'h2);
    go(8'h98, 10'd32, 3'h1);
    load(20, 16'd20);
    final_report();
  end
endmodule // tb_ctm_timer
